//--- core/srb_pkg.sv
// Shared constants and types for the read burst link between controller and memory.
// How it works
// - READ carries bank, column, auto precharge choice.
// - Auto precharge closes row; otherwise row stays.
// - First element appears read latency after READ.
// - Controller programs latencies before relying on them.
// - Two elements per clock after the first.
// - Strobe preamble: true low, complement high.
// - Strobe postamble low with final element.
// - Data lines released when burst ends.
// - Random column reads at full burst rate.
// - Length four bursts never interrupted.
// - Length eight cut only by READ.
// - Cutting READ exactly two clocks later.
// - No PRECHARGE during a cut sequence.
// - A10 high selects auto precharge.
// - Later elements follow programmed burst order.
// - Read data finishes before any write.
// - Explicit PRECHARGE only after non-auto READ.
// - READ to PRECHARGE spacing per formula.
// - Precharge time counted from last prefetch.
// - No bank command before precharge period.
// - Nanosecond minimums round up to clocks.
package srb_pkg;
  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int BA_W   = 3;
  localparam int AD_W   = 14;
  localparam int COL_W  = 10;
  localparam int DQ_W   = 8;
  localparam int NBANK  = 8;
  localparam int PIPE_D = 16;
  localparam int CNT_W  = 6;

  // ------------------------------------------------------------------
  // Commands on {ras_n, cas_n, we_n} and request codes
  // ------------------------------------------------------------------
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [1:0] OP_ACT  = 2'h0;
  localparam logic [1:0] OP_RD   = 2'h1;
  localparam logic [1:0] OP_PRE  = 2'h2;

  // ------------------------------------------------------------------
  // Mode load fields
  // ------------------------------------------------------------------
  localparam int MR_BT_BIT  = 3;
  localparam int MR_CL_LSB  = 4;
  localparam int EMR_AL_LSB = 3;
  localparam int AP_BIT     = 10;
  localparam logic [2:0]      BL4_CODE = 3'h2;
  localparam logic [2:0]      BL8_CODE = 3'h3;
  localparam logic [BA_W-1:0] BA_MR    = 3'h0;
  localparam logic [BA_W-1:0] BA_EMR   = 3'h1;

  // Settings the controller programs after wake-up.
  localparam logic [2:0] AL_CFG  = 3'h1;
  localparam logic [2:0] CL_CFG  = 3'h3;
  localparam logic       BL8_CFG = 1'b1;
  localparam logic       ILV_CFG = 1'b0;
  localparam int         HALF_BL = BL8_CFG ? 4 : 2;
  localparam logic [AD_W-1:0] MR_WORD = (AD_W'(CL_CFG) << MR_CL_LSB)
                                      | (AD_W'(ILV_CFG) << MR_BT_BIT)
                                      | AD_W'(BL8_CFG ? BL8_CODE : BL4_CODE);
  localparam logic [AD_W-1:0] EMR_WORD = AD_W'(AL_CFG) << EMR_AL_LSB;

  // ------------------------------------------------------------------
  // Timing, in picoseconds and link clocks
  // ------------------------------------------------------------------
  function automatic int srb_ceil(input int a, input int b);
    return (a + b - 1) / b;
  endfunction : srb_ceil

  localparam int REF_PS    = 5000;
  localparam int CK_PS     = 2 * REF_PS;
  localparam int RTP_PS    = 7500;
  localparam int RP_PS     = 15000;
  localparam int RTP_CK    = srb_ceil(RTP_PS, CK_PS);
  localparam int RP_CK     = srb_ceil(RP_PS, CK_PS);
  localparam int RD2PRE_CK = int'(AL_CFG) + HALF_BL - 2 + (RTP_CK > 2 ? RTP_CK : 2);
  localparam int APBUSY_CK = int'(AL_CFG) + HALF_BL - 2 + srb_ceil(RTP_PS + RP_PS, CK_PS);
  localparam int WAKE_CK   = 4;
  localparam int MRD_CK    = 2;
  localparam int CUT_GAP   = 2;

  // One queued read on its way to the data pins.
  typedef struct packed {
    logic             v;
    logic [BA_W-1:0]  ba;
    logic [COL_W-1:0] col;
    logic             ap;
    logic             bl8;
    logic             ilv;
  } srb_slot_s;
endpackage : srb_pkg

//--- core/srb_link_if.sv
// Link between the memory controller and the memory device.
`timescale 1ns/100ps
interface srb_link_if;
  import srb_pkg::*;
  logic            ck;
  logic            cke;
  logic            cs_n;
  logic            ras_n;
  logic            cas_n;
  logic            we_n;
  logic [BA_W-1:0] ba;
  logic [AD_W-1:0] addr;
  logic [DQ_W-1:0] dq_rise;
  logic [DQ_W-1:0] dq_fall;
  logic            dq_oe;
  logic            dqs_t;
  logic            dqs_c;
  logic            dqs_oe;

  modport host (output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
                input  dq_rise, dq_fall, dq_oe, dqs_t, dqs_c, dqs_oe);
  modport dev  (input  ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
                output dq_rise, dq_fall, dq_oe, dqs_t, dqs_c, dqs_oe);
endinterface : srb_link_if

//--- core/srb_bank_cnt.sv
// Down counter that tells when a bank spacing has run out.
`timescale 1ns/100ps
module srb_bank_cnt
  import srb_pkg::*;
(
  // Clock and reset.
  input  logic             ref_clk_i,
  input  logic             srst_i,
  // Count control.
  input  logic             tick_i,
  input  logic             ld_i,
  input  logic [CNT_W-1:0] val_i,
  // Status.
  output logic             zero_o
);
  logic [CNT_W-1:0] cnt_q;

  // A load wins over the decrement so a fresh spacing is never shortened.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
    end else if (ld_i) begin
      cnt_q <= val_i;
    end else if (tick_i && cnt_q != '0) begin
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end

  assign zero_o = (cnt_q == '0);
endmodule : srb_bank_cnt

//--- core/srb_dev.sv
// Memory device end: read command decode, latency pipe and burst output.
`timescale 1ns/100ps
module srb_dev
  import srb_pkg::*;
(
  // Link to the controller.
  srb_link_if.dev         link,
  // Row state.
  output logic [NBANK-1:0] bank_open_o
);
  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  // Clock enable low holds the device in reset; the controller keeps the clock running through wake-up, but holds it low during its own reset.
  wire       rst    = !link.cke;
  wire [2:0] cmd    = {link.ras_n, link.cas_n, link.we_n};
  wire       is_rd  = !link.cs_n && cmd == CMD_RD;
  wire       is_act = !link.cs_n && cmd == CMD_ACT;
  wire       is_pre = !link.cs_n && cmd == CMD_PRE;
  wire       is_mrs = !link.cs_n && cmd == CMD_MRS;

  logic [2:0] al_q;
  logic [2:0] cl_q;
  logic       bl8_q;
  logic       ilv_q;
  wire  [3:0] rl = {1'b0, al_q} + {1'b0, cl_q};

  srb_slot_s  pipe_q [PIPE_D];
  srb_slot_s  cur_q;
  srb_slot_s  new_slot;
  logic       act_q;
  logic [1:0] idx_q;

  assign new_slot = '{v: 1'b1, ba: link.ba, col: link.addr[COL_W-1:0],
                      ap: link.addr[AP_BIT], bl8: bl8_q, ilv: ilv_q};

  // Column visited by element i and the pattern returned for it.
  function automatic logic [DQ_W-1:0] elem(input srb_slot_s s, input logic [2:0] i);
    logic [2:0] mask;
    logic [2:0] off;
    mask = s.bl8 ? 3'h7 : 3'h3;
    off  = (s.ilv ? (s.col[2:0] ^ i) : (s.col[2:0] + i)) & mask;
    return {s.ba, s.col[4:3], (s.col[2:0] & ~mask) | off};
  endfunction : elem

  // ------------------------------------------------------------------
  // Mode settings and row state
  // ------------------------------------------------------------------
  always_ff @(posedge link.ck) begin
    if (rst) begin
      al_q  <= '0;
      cl_q  <= '0;
      bl8_q <= 1'b0;
      ilv_q <= 1'b0;
    end else if (is_mrs && link.ba == BA_MR) begin
      cl_q  <= link.addr[MR_CL_LSB +: 3];
      ilv_q <= link.addr[MR_BT_BIT];
      bl8_q <= link.addr[2:0] == BL8_CODE;
    end else if (is_mrs && link.ba == BA_EMR) begin
      al_q  <= link.addr[EMR_AL_LSB +: 3];
    end
  end

  // ------------------------------------------------------------------
  // Latency pipe: a READ enters at read latency minus one and walks down
  // ------------------------------------------------------------------
  always_ff @(posedge link.ck) begin
    for (int i = 0; i < PIPE_D; i++) begin
      if (rst) begin
        pipe_q[i] <= '0;
      end else if (is_rd && (rl - 4'h1) == 4'(i)) begin
        pipe_q[i] <= new_slot;
      end else if (i == PIPE_D - 1) begin
        pipe_q[i] <= '0;
      end else begin
        pipe_q[i] <= pipe_q[(i + 1) % PIPE_D];
      end
    end
  end

  // ------------------------------------------------------------------
  // Burst sequencing
  // ------------------------------------------------------------------
  // A head slot always takes over, which gives both gapless chaining and truncation.
  wire        start    = pipe_q[0].v;
  wire        follow   = pipe_q[1].v;
  wire        at_end   = act_q && idx_q == (cur_q.bl8 ? 2'h3 : 2'h1);
  wire        act_d    = start | (act_q & ~at_end);
  srb_slot_s  cur_d;
  assign cur_d = start ? pipe_q[0] : cur_q;
  wire  [1:0] idx_d    = (start | at_end) ? 2'h0 : idx_q + 2'h1;
  wire        last_d   = act_d && idx_d == (cur_d.bl8 ? 2'h3 : 2'h1);
  wire        pre_d    = follow && !act_d;
  wire        dqs_t_d  = act_d && !(last_d && !follow);
  wire  [2:0] el_r     = {idx_d, 1'b0};
  wire  [2:0] el_f     = {idx_d, 1'b1};

  always_ff @(posedge link.ck) begin
    if (rst) begin
      act_q <= 1'b0;
      idx_q <= 2'h0;
      cur_q <= '0;
    end else begin
      act_q <= act_d;
      idx_q <= idx_d;
      cur_q <= cur_d;
    end
  end

  // ------------------------------------------------------------------
  // Pin drivers: two elements per clock, strobe framed by pre and postamble
  // ------------------------------------------------------------------
  always_ff @(posedge link.ck) begin
    if (rst) begin
      link.dq_rise <= '0;
      link.dq_fall <= '0;
      link.dq_oe   <= 1'b0;
      link.dqs_t   <= 1'b0;
      link.dqs_c   <= 1'b0;
      link.dqs_oe  <= 1'b0;
    end else begin
      link.dq_rise <= act_d ? elem(cur_d, el_r) : '0;
      link.dq_fall <= act_d ? elem(cur_d, el_f) : '0;
      link.dq_oe   <= act_d;
      link.dqs_t   <= dqs_t_d;
      link.dqs_c   <= (act_d | pre_d) & ~dqs_t_d;
      link.dqs_oe  <= act_d | pre_d;
    end
  end

  // Rows: opened by ACTIVATE, closed by PRECHARGE or when an auto precharge burst ends.
  always_ff @(posedge link.ck) begin
    if (rst) begin
      bank_open_o <= '0;
    end else begin
      for (int b = 0; b < NBANK; b++) begin
        if (is_act && link.ba == BA_W'(b)) begin
          bank_open_o[b] <= 1'b1;
        end else if (is_pre && (link.addr[AP_BIT] || link.ba == BA_W'(b))) begin
          bank_open_o[b] <= 1'b0;
        end else if (at_end && cur_q.ap && cur_q.ba == BA_W'(b)) begin
          bank_open_o[b] <= 1'b0;
        end
      end
    end
  end
endmodule : srb_dev

//--- core/srb_host.sv
// Memory controller end: link clock, mode setup, spacing guards and read capture.
`timescale 1ns/100ps
module srb_host
  import srb_pkg::*;
(
  // Clock and reset.
  input  logic              ref_clk_i,
  input  logic              srst_i,
  // Link to the memory device.
  srb_link_if.host          link,
  // Command requests.
  input  logic              req_valid_i,
  output logic              req_ready_o,
  input  logic [1:0]        req_op_i,
  input  logic [BA_W-1:0]   req_ba_i,
  input  logic [AD_W-1:0]   req_row_i,
  input  logic [COL_W-1:0]  req_col_i,
  input  logic              req_ap_i,
  input  logic              req_cut_i,
  // Read data returned.
  output logic              rd_valid_o,
  output logic [2*DQ_W-1:0] rd_data_o,
  // Status.
  output logic              init_done_o
);
  typedef enum logic [3:0] {
    ST_WAKE = 4'b0001,
    ST_MR   = 4'b0010,
    ST_EMR  = 4'b0100,
    ST_RUN  = 4'b1000
  } srb_host_state_e;

  srb_host_state_e st_q;
  srb_host_state_e st_d;
  logic [3:0]      wait_q;
  logic [3:0]      wait_d;
  logic            ck_q;
  logic            cke_q;
  logic [2:0]      cmd_q;
  logic [2:0]      cmd_d;
  logic [BA_W-1:0] ba_q;
  logic [BA_W-1:0] ba_d;
  logic [AD_W-1:0] addr_q;
  logic [AD_W-1:0] addr_d;
  logic [3:0]      gap_q;
  logic            cut_arm_q;
  logic [NBANK-1:0] ap_q;
  logic [NBANK-1:0] pre_ok;
  logic [NBANK-1:0] rp_ok;

  // ------------------------------------------------------------------
  // Link clock
  // ------------------------------------------------------------------
  // The link clock is the reference halved, so commands launched on the
  // reference edge where it falls are stable half a link period around
  // the device's rising edge.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ck_q <= 1'b0;
    end else begin
      ck_q <= ~ck_q;
    end
  end

  wire tick = ck_q;

  // ------------------------------------------------------------------
  // Spacing checks for the request at the port
  // ------------------------------------------------------------------
  wire [BA_W-1:0] b = req_ba_i;

  // Between a length eight READ and the READ that may cut it, only idle cycles go out.
  wire quiet   = cut_arm_q && gap_q < 4'(CUT_GAP);

  // Reads go out at half a burst, or exactly two clocks after a cuttable READ.
  wire cut_now = req_cut_i && cut_arm_q && gap_q == 4'(CUT_GAP);
  wire rd_ok   = rp_ok[b] && (gap_q >= 4'(HALF_BL) || cut_now);
  wire pre_ok_w = pre_ok[b] && rp_ok[b] && !quiet;
  wire act_ok  = rp_ok[b] && !quiet;

  wire op_ok   = (req_op_i == OP_RD)  ? rd_ok :
                 (req_op_i == OP_PRE) ? pre_ok_w :
                 (req_op_i == OP_ACT) ? act_ok : 1'b1;

  // Nothing is taken before both mode loads are out and settled.
  assign req_ready_o = tick && st_q == ST_RUN && wait_q == '0 && op_ok;

  wire fire    = req_valid_i && req_ready_o;
  wire fire_rd = fire && req_op_i == OP_RD;
  wire fire_pr = fire && req_op_i == OP_PRE;
  wire fire_ac = fire && req_op_i == OP_ACT;

  // A10 carries the auto precharge choice of a READ.
  wire [AD_W-1:0] rd_addr = AD_W'(req_col_i) | (AD_W'(req_ap_i) << AP_BIT);

  // An explicit PRECHARGE after an auto precharge READ is swallowed.
  wire [2:0] run_cmd = fire_rd ? CMD_RD :
                       fire_ac ? CMD_ACT :
                       (fire_pr && !ap_q[b]) ? CMD_PRE : CMD_NOP;

  wire [AD_W-1:0] run_addr = fire_rd ? rd_addr : fire_ac ? req_row_i : '0;

  // ------------------------------------------------------------------
  // Sequencer: wake-up with clock enable low, two mode loads, then run
  // ------------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    wait_d = wait_q;
    cmd_d  = CMD_NOP;
    ba_d   = ba_q;
    addr_d = addr_q;
    if (tick) begin
      wait_d = (wait_q == '0) ? '0 : wait_q - 4'h1;
      case (st_q)
        ST_WAKE: begin
          if (wait_q == '0) begin
            st_d = ST_MR;
          end
        end
        ST_MR: begin
          cmd_d  = CMD_MRS;
          ba_d   = BA_MR;
          addr_d = MR_WORD;
          wait_d = 4'(MRD_CK - 1);
          st_d   = ST_EMR;
        end
        ST_EMR: begin
          if (wait_q == '0) begin
            cmd_d  = CMD_MRS;
            ba_d   = BA_EMR;
            addr_d = EMR_WORD;
            wait_d = 4'(MRD_CK - 1);
            st_d   = ST_RUN;
          end
        end
        ST_RUN: begin
          cmd_d  = run_cmd;
          ba_d   = fire ? req_ba_i : ba_q;
          addr_d = fire ? run_addr : addr_q;
        end
        default: begin
          st_d = ST_WAKE;
        end
      endcase
    end
  end

  // Command pins change only on the reference edge where the link clock falls.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_q   <= ST_WAKE;
      wait_q <= 4'(WAKE_CK - 1);
      cke_q  <= 1'b0;
      cmd_q  <= CMD_NOP;
      ba_q   <= '0;
      addr_q <= '0;
    end else if (tick) begin
      st_q   <= st_d;
      wait_q <= wait_d;
      cke_q  <= st_d != ST_WAKE;
      cmd_q  <= cmd_d;
      ba_q   <= ba_d;
      addr_q <= addr_d;
    end
  end

  assign link.ck    = ck_q;
  assign link.cke   = cke_q;
  assign link.cs_n  = cmd_q == CMD_NOP;
  assign link.ras_n = cmd_q[2];
  assign link.cas_n = cmd_q[1];
  assign link.we_n  = cmd_q[0];
  assign link.ba    = ba_q;
  assign link.addr  = addr_q;
  assign init_done_o = st_q == ST_RUN;

  // ------------------------------------------------------------------
  // Read spacing state
  // ------------------------------------------------------------------
  // Clocks since the last READ; saturates so a long idle never wraps into a cut slot.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      gap_q     <= '1;
      cut_arm_q <= 1'b0;
    end else if (fire_rd) begin
      gap_q     <= 4'h1;
      cut_arm_q <= BL8_CFG && !req_ap_i;
    end else if (tick && gap_q != '1) begin
      gap_q     <= gap_q + 4'h1;
    end
  end

  // Banks whose last READ asked for auto precharge; a new ACTIVATE clears the mark.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ap_q <= '0;
    end else if (fire_rd) begin
      ap_q[b] <= req_ap_i;
    end else if (fire_ac) begin
      ap_q[b] <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Per-bank spacing counters in link clocks
  // ------------------------------------------------------------------
  // Precharge time is counted from the last prefetch, which the combined
  // spacing already folds in; auto precharge busy time covers the hidden precharge.
  for (genvar g = 0; g < NBANK; g++) begin : g_bank
    wire hit = b == BA_W'(g);

    srb_bank_cnt u_pre (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .tick_i    (tick),
      .ld_i      (fire_rd && hit),
      .val_i     (CNT_W'(RD2PRE_CK)),
      .zero_o    (pre_ok[g])
    );

    srb_bank_cnt u_rp (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .tick_i    (tick),
      .ld_i      ((fire_pr || (fire_rd && req_ap_i)) && hit),
      .val_i     (fire_pr ? CNT_W'(RP_CK) : CNT_W'(APBUSY_CK)),
      .zero_o    (rp_ok[g])
    );
  end

  // ------------------------------------------------------------------
  // Read data capture
  // ------------------------------------------------------------------
  // Two stages before use: the device launches on the link rising edge and
  // the first stage samples half a link period later. No write path exists,
  // so a write can never overlap read data on the lines.
  logic              oe1_q;
  logic              oe2_q;
  logic              ph1_q;
  logic              ph2_q;
  logic [2*DQ_W-1:0] dat1_q;
  logic [2*DQ_W-1:0] dat2_q;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      oe1_q  <= 1'b0;
      oe2_q  <= 1'b0;
      ph1_q  <= 1'b0;
      ph2_q  <= 1'b0;
      dat1_q <= '0;
      dat2_q <= '0;
    end else begin
      oe1_q  <= link.dq_oe;
      dat1_q <= {link.dq_rise, link.dq_fall};
      ph1_q  <= ck_q;
      oe2_q  <= oe1_q;
      dat2_q <= dat1_q;
      ph2_q  <= ph1_q;
    end
  end

  assign rd_valid_o = oe2_q && ph2_q;
  assign rd_data_o  = dat2_q;
endmodule : srb_host

//--- dv/srb_link_checker.sv
// Concurrent checks on the link between controller and memory.
`timescale 1ns/100ps
module srb_link_checker
  import srb_pkg::*;
(
  // Link clock and command pins.
  input logic            ck,
  input logic            cke,
  input logic            cs_n,
  input logic            ras_n,
  input logic            cas_n,
  input logic            we_n,
  input logic [BA_W-1:0] ba,
  input logic [AD_W-1:0] addr,
  // Data and strobe pins.
  input logic [DQ_W-1:0] dq_rise,
  input logic [DQ_W-1:0] dq_fall,
  input logic            dq_oe,
  input logic            dqs_t,
  input logic            dqs_c,
  input logic            dqs_oe
);
  // Command decode; cke low is the device reset, so it disables every check.
  logic rd;
  logic pre;
  assign rd  = !cs_n && ({ras_n, cas_n, we_n} == CMD_RD);
  assign pre = !cs_n && ({ras_n, cas_n, we_n} == CMD_PRE);

  property p_rd_latency;
    @(posedge ck) disable iff (!cke) rd |-> ##5 dq_oe;
  endproperty
  a_rd_latency: assert property (p_rd_latency) else $error("read data late");
  property p_preamble;
    @(posedge ck) disable iff (!cke) $rose(dqs_oe) |-> !dqs_t && dqs_c && !dq_oe;
  endproperty
  a_preamble: assert property (p_preamble) else $error("bad preamble");
  property p_strobe_with_data;
    @(posedge ck) disable iff (!cke) dq_oe |-> dqs_oe;
  endproperty
  a_strobe_with_data: assert property (p_strobe_with_data) else $error("no strobe");
  property p_postamble;
    @(posedge ck) disable iff (!cke) $fell(dq_oe) |-> !$past(dqs_t) && $past(dqs_c);
  endproperty
  a_postamble: assert property (p_postamble) else $error("bad postamble");
  property p_release;
    @(posedge ck) disable iff (!cke) !dq_oe |-> (dq_rise == '0) && (dq_fall == '0);
  endproperty
  a_release: assert property (p_release) else $error("data not released");
  property p_two_per_ck;
    @(posedge ck) disable iff (!cke) $rose(dq_oe) |-> dq_oe[*4];
  endproperty
  a_two_per_ck: assert property (p_two_per_ck) else $error("burst short");
  // A second READ lands either 2 clocks later as a cut or 4 or more later.
  property p_cut_gap;
    @(posedge ck) disable iff (!cke) rd |-> ##1 !rd ##2 !rd;
  endproperty
  a_cut_gap: assert property (p_cut_gap) else $error("read spacing");
  property p_no_pre_in_cut;
    @(posedge ck) disable iff (!cke) rd && !addr[AP_BIT] |=> !pre;
  endproperty
  a_no_pre_in_cut: assert property (p_no_pre_in_cut) else $error("pre in cut");
  // With the programmed settings the spacing is five clocks, so a same-bank READ
  // in any of the four clocks before a PRECHARGE is too close.
  property p_rd2pre;
    @(posedge ck) disable iff (!cke)
      pre |-> !($past(rd) && $past(ba) == ba) && !($past(rd, 2) && $past(ba, 2) == ba)
          && !($past(rd, 3) && $past(ba, 3) == ba) && !($past(rd, 4) && $past(ba, 4) == ba);
  endproperty
  a_rd2pre: assert property (p_rd2pre) else $error("pre too soon");
  property p_row_precharge;
    @(posedge ck) disable iff (!cke) !cs_n |-> !($past(pre) && $past(ba) == ba);
  endproperty
  a_row_precharge: assert property (p_row_precharge) else $error("cmd in precharge");
endmodule : srb_link_checker

//--- dv/test_srb_read_burst.sv
// Self-checking bench for the controller and memory ends joined by the link.
`timescale 1ns/100ps
module test_srb_read_burst
  import srb_pkg::*;
;
  logic              ref_clk_i   = 1'b0;
  logic              srst_i      = 1'b1;
  logic              req_valid_i = 1'b0;
  logic [1:0]        req_op_i    = 2'h0;
  logic [BA_W-1:0]   req_ba_i    = '0;
  logic [AD_W-1:0]   req_row_i   = '0;
  logic [COL_W-1:0]  req_col_i   = '0;
  logic              req_ap_i    = 1'b0;
  logic              req_cut_i   = 1'b0;
  logic              req_ready_o;
  logic              rd_valid_o;
  logic [2*DQ_W-1:0] rd_data_o;
  logic              init_done_o;
  logic [NBANK-1:0]  bank_open_o;
  logic [15:0]       exp_q[$];
  int                fail_count   = 0;
  int                total_checks = 0;

  srb_link_if link_if();
  srb_host srb_host_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .link(link_if),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_op_i(req_op_i),
    .req_ba_i(req_ba_i), .req_row_i(req_row_i), .req_col_i(req_col_i), .req_ap_i(req_ap_i),
    .req_cut_i(req_cut_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .init_done_o(init_done_o));
  srb_dev srb_dev_i (.link(link_if), .bank_open_o(bank_open_o));
  srb_link_checker srb_link_checker_i (.ck(link_if.ck), .cke(link_if.cke),
    .cs_n(link_if.cs_n), .ras_n(link_if.ras_n), .cas_n(link_if.cas_n), .we_n(link_if.we_n),
    .ba(link_if.ba), .addr(link_if.addr), .dq_rise(link_if.dq_rise),
    .dq_fall(link_if.dq_fall), .dq_oe(link_if.dq_oe), .dqs_t(link_if.dqs_t),
    .dqs_c(link_if.dqs_c), .dqs_oe(link_if.dqs_oe));

  // Reference clock, 5 ns period.
  always #2.5 ref_clk_i = ~ref_clk_i;

  task automatic finish_test;
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Element i of a sequential burst is {bank, col[4:3], col[2:0] + i}.
  function automatic logic [15:0] exp_word(input logic [BA_W-1:0] b,
                                           input logic [COL_W-1:0] c, input int k);
    logic [2:0] e0;
    logic [2:0] e1;
    e0 = c[2:0] + 3'(2 * k);
    e1 = c[2:0] + 3'(2 * k + 1);
    return {b, c[4:3], e0, b, c[4:3], e1};
  endfunction : exp_word

  // Holds the request until ready is seen mid-cycle, then drops it at the next rising edge; ready waits for spacing.
  task automatic req(input logic [1:0] op, input logic [BA_W-1:0] b,
                     input logic [COL_W-1:0] c, input logic ap, input logic cut);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    req_valid_i <= 1'b1;
    req_op_i    <= op;
    req_ba_i    <= b;
    req_row_i   <= AD_W'($urandom);
    req_col_i   <= c;
    req_ap_i    <= ap;
    req_cut_i   <= cut;
    // Ready is looked at mid-cycle only, never in the time step of the edge that moves it.
    @(negedge ref_clk_i);
    while (n < 400 && req_ready_o !== 1'b1) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(posedge ref_clk_i);
    req_valid_i <= 1'b0;
    check("req_ready_o", 16'h0001, {15'h0000, n < 400});
  endtask : req

  task automatic rd(input logic [BA_W-1:0] b, input logic [COL_W-1:0] c,
                    input logic ap, input logic cut, input int n);
    req(OP_RD, b, c, ap, cut);
    for (int k = 0; k < n; k++) exp_q.push_back(exp_word(b, c, k));
  endtask : rd

  // Every returned pair is matched against the expected stream in order.
  always @(posedge ref_clk_i) begin
    if (rd_valid_o === 1'b1) begin
      if (exp_q.size() == 0) check("rd_valid_o", 16'h0000, 16'h0001);
      else check("rd_data_o", exp_q.pop_front(), rd_data_o);
    end
  end

  // Main sequence.
  initial begin
    void'($urandom(32'hd56c8347));
    repeat (2) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    @(negedge ref_clk_i);
    check("init_done_o", 16'h0000, {15'h0000, init_done_o});
    for (int b = 0; b < NBANK; b++) req(OP_ACT, 3'(b), '0, 1'b0, 1'b0);
    for (int i = 0; i < 12; i++) rd(3'($urandom_range(0, 4)), COL_W'($urandom), 0, 0, 4);
    rd(3'h1, 10'h0007, 1'b0, 1'b0, 2);
    rd(3'h5, COL_W'($urandom), 1'b1, 1'b1, 4);
    rd(3'h6, COL_W'($urandom), 1'b1, 1'b0, 4);
    rd(3'h7, COL_W'($urandom), 1'b0, 1'b0, 4);
    req(OP_PRE, 3'h7, '0, 1'b0, 1'b0);
    req(OP_PRE, 3'h6, '0, 1'b0, 1'b0);
    repeat (80) @(posedge ref_clk_i);
    check("pending", 16'h0000, 16'(exp_q.size()));
    check("open5", 16'h0000, {15'h0000, bank_open_o[5]});
    check("open6", 16'h0000, {15'h0000, bank_open_o[6]});
    check("open7", 16'h0000, {15'h0000, bank_open_o[7]});
    check("open0", 16'h0001, {15'h0000, bank_open_o[0]});
    check("init_done_o", 16'h0001, {15'h0000, init_done_o});
    finish_test();
  end

  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    finish_test();
  end
endmodule : test_srb_read_burst
